// ==== bench/pin_driver_model.sv ====
// model of the trigger/direction pin and external count pin sources
`timescale 1ns/10ps
module pin_driver_model (
   input  wire logic pclk,
   output logic      trig,
   output logic      cnt
);
   initial begin
      trig = 1'b1;
      cnt  = 1'b1;
   end
   // each level held three edges, above the two the synchroniser needs
   task automatic fall_trig();
      trig <= 1'b0;
      repeat (3) @(posedge pclk);
      trig <= 1'b1;
      repeat (3) @(posedge pclk);
   endtask
   task automatic set_trig(input logic v);
      trig <= v;
      repeat (3) @(posedge pclk);
   endtask
   task automatic fall_cnt();
      cnt <= 1'b0;
      repeat (3) @(posedge pclk);
      cnt <= 1'b1;
      repeat (3) @(posedge pclk);
   endtask
endmodule

// ==== bench/timer2_capture_reload_counter_tb.sv ====
// self-checking bench for the capture / reload timer
`timescale 1ns/10ps
module timer2_capture_reload_counter_tb;
   localparam logic [7:0] CT = timer_two_pkg::CONTROL_OFFSET;
   localparam logic [7:0] MD = timer_two_pkg::MODE_OFFSET;
   localparam logic [7:0] CL = timer_two_pkg::COUNT_LOW_OFFSET;
   localparam logic [7:0] CH = timer_two_pkg::COUNT_HIGH_OFFSET;
   localparam logic [7:0] RL = timer_two_pkg::RELOAD_LOW_OFFSET;
   localparam logic [7:0] RH = timer_two_pkg::RELOAD_HIGH_OFFSET;
   localparam logic [7:0] IE = timer_two_pkg::IRQ_ENABLE_OFFSET;
   logic        pclk, presetn, psel, penable, pwrite, aux, irq, rxc, txc, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        trig, cnt, err;
   logic [7:0]  v;
   int          fails, check_count, rxn, txn;
   pin_driver_model model_u (.pclk(pclk), .trig(trig), .cnt(cnt));
   timer_two_counter dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .trigger_direction_pin(trig), .external_count_input(cnt),
      .aux_timer_overflow(aux), .timer_irq(irq), .rx_baud_clock(rxc), .tx_baud_clock(txc));
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      v = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      apb(1'b0, a, 8'h00);
      cmp(v, exp);
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rdc(CT, 8'h00);
      rdc(MD, 8'h00);
      rdc(RL, 8'h00);
      apb(1'b0, 8'h1C, 8'h00);
      cmp({7'h00, err}, 8'h01);
      $display("test reset done");
   endtask
   task automatic t_ignore();
      wr(CL, 8'h55);
      wr(CT, 8'h01);
      model_u.fall_trig();
      rdc(RL, 8'h00);
      rdc(CT, 8'h01);
      $display("test ignore done");
   endtask
   task automatic t_capture();
      wr(CL, 8'hCD);
      wr(CH, 8'hAB);
      wr(CT, 8'h09);
      model_u.fall_trig();
      rdc(RL, 8'hCD);
      rdc(RH, 8'hAB);
      rdc(CT, 8'h49);
      rdc(CL, 8'hCD);
      wr(CT, 8'h00);
      rdc(CT, 8'h00);
      $display("test capture done");
   endtask
   task automatic t_overflow();
      int n;
      wr(RL, 8'h34);
      wr(RH, 8'h12);
      wr(CL, 8'hFF);
      wr(CH, 8'hFF);
      wr(IE, 8'h01);
      wr(CT, 8'h04);
      n = 0;
      while (irq !== 1'b1 && n < 60) begin
         @(posedge pclk);
         n++;
      end
      cmp({7'h00, irq}, 8'h01);
      rdc(CT, 8'h84);
      wr(CT, 8'h00);
      rdc(CH, 8'h12);
      cmp({7'h00, irq}, 8'h00);
      $display("test overflow done");
   endtask
   task automatic t_trig_reload();
      wr(CL, 8'h77);
      wr(CT, 8'h08);
      model_u.fall_trig();
      rdc(CL, 8'h34);
      rdc(CH, 8'h12);
      rdc(CT, 8'h48);
      wr(CT, 8'h00);
      $display("test trigger reload done");
   endtask
   task automatic t_updown();
      wr(MD, 8'h01);
      model_u.set_trig(1'b0);
      wr(RL, 8'h10);
      wr(RH, 8'h00);
      wr(CL, 8'h11);
      wr(CH, 8'h00);
      wr(CT, 8'h04);
      repeat (50) @(posedge pclk);
      rdc(CT, 8'hC4);
      wr(CT, 8'h44);
      repeat (3) @(posedge pclk);
      cmp({7'h00, irq}, 8'h00);
      wr(CT, 8'h00);
      rdc(CH, 8'hFF);
      model_u.set_trig(1'b1);
      wr(RH, 8'h33);
      wr(CL, 8'hFF);
      wr(CH, 8'hFF);
      wr(CT, 8'h04);
      repeat (30) @(posedge pclk);
      rdc(CT, 8'hC4);
      wr(CT, 8'h00);
      rdc(CH, 8'h33);
      wr(MD, 8'h00);
      $display("test up down done");
   endtask
   task automatic t_baud();
      wr(RL, 8'hF0);
      wr(RH, 8'hFF);
      wr(CL, 8'hFF);
      wr(CH, 8'hFF);
      wr(CT, 8'h24);
      rxn = 0;
      txn = 0;
      repeat (200) begin
         @(posedge pclk);
         rxn += rxc;
         txn += txc;
      end
      cmp(8'(rxn >= 5), 8'h01);
      cmp(8'(txn), 8'h00);
      rdc(CT, 8'h24);
      wr(CT, 8'h14);
      rxn = 0;
      txn = 0;
      repeat (100) begin
         @(posedge pclk);
         rxn += rxc;
         txn += txc;
      end
      cmp(8'(txn >= 2), 8'h01);
      cmp(8'(rxn), 8'h00);
      rdc(CT, 8'h14);
      wr(CT, 8'h00);
      rxn = 0;
      txn = 0;
      aux <= 1'b1;
      @(posedge pclk);
      aux <= 1'b0;
      repeat (4) begin
         @(posedge pclk);
         rxn += rxc;
         txn += txc;
      end
      cmp(8'(rxn), 8'h01);
      cmp(8'(txn), 8'h01);
      $display("test baud done");
   endtask
   task automatic t_extcount();
      wr(CL, 8'h00);
      wr(CH, 8'h00);
      wr(CT, 8'h06);
      repeat (3) model_u.fall_cnt();
      wr(CT, 8'h00);
      rdc(CL, 8'h03);
      $display("test external count done");
   endtask
   task automatic t_six_clock();
      wr(MD, 8'h02);
      wr(CL, 8'h00);
      wr(CH, 8'h00);
      wr(CT, 8'h04);
      repeat (58) @(posedge pclk);
      wr(CT, 8'h00);
      apb(1'b0, CL, 8'h00);
      cmp(8'(v >= 8'h09 && v <= 8'h0B), 8'h01);
      wr(MD, 8'h00);
      $display("test six clock done");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #(20000 * 100);
      fails++;
      $display("unexpected at %0t: watchdog expired", $time);
      report_and_stop();
   end
   initial begin
      fails = 0;
      check_count = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      aux = 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_ignore();
      t_capture();
      t_overflow();
      t_trig_reload();
      t_updown();
      t_baud();
      t_extcount();
      t_six_clock();
      report_and_stop();
   end
endmodule

// ==== rtl/pin_edge_sync.sv ====
// two-stage synchroniser with falling edge detect per pin
`timescale 1ns/10ps
module pin_edge_sync #(
   parameter int WIDTH = 2
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [WIDTH-1:0] pin,
   output logic      [WIDTH-1:0] level,
   output logic      [WIDTH-1:0] fall
);

   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] prev;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_pin
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               meta[i]  <= 1'b1;
               level[i] <= 1'b1;
               prev[i]  <= 1'b1;
            end else begin
               meta[i]  <= pin[i];
               level[i] <= meta[i];
               prev[i]  <= level[i];
            end
         end
         assign fall[i] = prev[i] & ~level[i];
      end
   endgenerate

endmodule

// ==== rtl/timer_two_counter.sv ====
// capture / auto-reload / baud timer with apb register slave
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
module timer_two_counter #(
   parameter int ADDR_WIDTH = 8
) (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [ADDR_WIDTH-1:0] paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic                  trigger_direction_pin,
   input  wire logic                  external_count_input,
   input  wire logic                  aux_timer_overflow,
   output logic                       timer_irq,
   output logic                       rx_baud_clock,
   output logic                       tx_baud_clock
);

   ////////////////////////////////////////////////////////////////////////////
   // state
   logic [7:0]  timer_two_control;
   logic [1:0]  timer_two_mode_reg;
   logic        interrupt_enable_reg;
   logic [15:0] count;
   logic [15:0] reload;
   logic [3:0]  prescale;

   logic        overflow_flag;
   logic        external_event_flag;
   logic        receive_baud_select;
   logic        transmit_baud_select;
   logic        external_trigger_enable;
   logic        run_control;
   logic        count_source_select;
   logic        capture_reload_select;
   logic        down_count_enable;
   logic        six_clock_mode;

   assign overflow_flag           = timer_two_control[timer_two_pkg::OVERFLOW_BIT];
   assign external_event_flag     = timer_two_control[timer_two_pkg::EXT_FLAG_BIT];
   assign receive_baud_select     = timer_two_control[timer_two_pkg::RX_BAUD_BIT];
   assign transmit_baud_select    = timer_two_control[timer_two_pkg::TX_BAUD_BIT];
   assign external_trigger_enable = timer_two_control[timer_two_pkg::TRIGGER_ENABLE_BIT];
   assign run_control             = timer_two_control[timer_two_pkg::RUN_BIT];
   assign count_source_select     = timer_two_control[timer_two_pkg::SOURCE_BIT];
   assign capture_reload_select   = timer_two_control[timer_two_pkg::CAPTURE_BIT];
   assign down_count_enable       = timer_two_mode_reg[timer_two_pkg::DOWN_ENABLE_BIT];
   assign six_clock_mode          = timer_two_mode_reg[timer_two_pkg::SIX_CLOCK_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [1:0] pin_level;
   logic [1:0] pin_fall;
   logic       trigger_level;
   logic       trigger_fall;
   logic       count_pin_fall;

   pin_edge_sync #(
      .WIDTH (2)
   ) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .pin     ({external_count_input, trigger_direction_pin}),
      .level   (pin_level),
      .fall    (pin_fall)
   );

   assign trigger_level  = pin_level[0];
   assign trigger_fall   = pin_fall[0];
   assign count_pin_fall = pin_fall[1];

   ////////////////////////////////////////////////////////////////////////////
   // apb decode
   logic apb_done;
   logic wr_en;
   logic addr_ok;

   assign apb_done = psel & penable & pready;
   assign wr_en    = apb_done & pwrite;

   always_comb begin
      case (paddr)
         timer_two_pkg::CONTROL_OFFSET,
         timer_two_pkg::MODE_OFFSET,
         timer_two_pkg::COUNT_LOW_OFFSET,
         timer_two_pkg::COUNT_HIGH_OFFSET,
         timer_two_pkg::RELOAD_LOW_OFFSET,
         timer_two_pkg::RELOAD_HIGH_OFFSET,
         timer_two_pkg::IRQ_ENABLE_OFFSET: addr_ok = 1'b1;
         default:                          addr_ok = 1'b0;
      endcase
   end

   logic wr_control;
   logic wr_mode;
   logic wr_count_low;
   logic wr_count_high;
   logic wr_reload_low;
   logic wr_reload_high;
   logic wr_irq_enable;

   assign wr_control     = wr_en & (paddr == timer_two_pkg::CONTROL_OFFSET);
   assign wr_mode        = wr_en & (paddr == timer_two_pkg::MODE_OFFSET);
   assign wr_count_low   = wr_en & (paddr == timer_two_pkg::COUNT_LOW_OFFSET);
   assign wr_count_high  = wr_en & (paddr == timer_two_pkg::COUNT_HIGH_OFFSET);
   assign wr_reload_low  = wr_en & (paddr == timer_two_pkg::RELOAD_LOW_OFFSET);
   assign wr_reload_high = wr_en & (paddr == timer_two_pkg::RELOAD_HIGH_OFFSET);
   assign wr_irq_enable  = wr_en & (paddr == timer_two_pkg::IRQ_ENABLE_OFFSET);

   ////////////////////////////////////////////////////////////////////////////
   // mode decode and count tick
   logic       baud_mode;
   logic       capture_mode;
   logic       up_down_mode;
   logic       counting_down;
   logic [3:0] tick_div;
   logic       internal_tick;
   logic       count_step;

   assign baud_mode     = receive_baud_select | transmit_baud_select;
   assign capture_mode  = ~baud_mode & capture_reload_select;
   assign up_down_mode  = ~baud_mode & ~capture_reload_select & down_count_enable;
   assign counting_down = up_down_mode & ~trigger_level;

   always_comb begin
      if (baud_mode) begin
         tick_div = six_clock_mode ? timer_two_pkg::BAUD_DIV_6CLK
                                   : timer_two_pkg::BAUD_DIV_12CLK;
      end else begin
         tick_div = six_clock_mode ? timer_two_pkg::TICK_DIV_6CLK
                                   : timer_two_pkg::TICK_DIV_12CLK;
      end
   end

   assign internal_tick = (prescale >= tick_div - 4'h1);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prescale <= 4'h0;
      end else if (internal_tick || !run_control) begin
         prescale <= 4'h0;
      end else begin
         prescale <= prescale + 4'h1;
      end
   end

   assign count_step = run_control &
                       (count_source_select ? count_pin_fall : internal_tick);

   ////////////////////////////////////////////////////////////////////////////
   // wrap and trigger events
   logic wrap_up;
   logic wrap_down;
   logic wrap_event;
   logic trigger_event;
   logic trigger_reload;
   logic trigger_capture;

   assign wrap_up    = count_step & ~counting_down & (count == timer_two_pkg::COUNT_ALL_ONES);
   assign wrap_down  = count_step & counting_down & (count == reload);
   assign wrap_event = wrap_up | wrap_down;

   assign trigger_event   = trigger_fall & external_trigger_enable & ~up_down_mode;
   assign trigger_reload  = trigger_event & ~baud_mode & ~capture_reload_select;
   assign trigger_capture = trigger_event & capture_mode;

   ////////////////////////////////////////////////////////////////////////////
   // count register
   logic [15:0] next_count;

   always_comb begin
      next_count = count;
      if (trigger_reload) begin
         next_count = reload;
      end else if (wrap_down) begin
         next_count = timer_two_pkg::COUNT_ALL_ONES;
      end else if (wrap_up && !capture_mode) begin
         next_count = reload;
      end else if (count_step) begin
         next_count = counting_down ? count - 16'h0001 : count + 16'h0001;
      end
      if (wr_count_low) begin
         next_count[7:0] = pwdata[7:0];
      end
      if (wr_count_high) begin
         next_count[15:8] = pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= timer_two_pkg::COUNT_RESET;
      end else begin
         count <= next_count;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // capture / reload pair
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reload <= timer_two_pkg::RELOAD_RESET;
      end else if (trigger_capture) begin
         reload <= count;
      end else if (wr_reload_low) begin
         reload[7:0] <= pwdata[7:0];
      end else if (wr_reload_high) begin
         reload[15:8] <= pwdata[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control, mode and enable registers
   logic set_overflow;
   logic set_external;
   logic toggle_external;

   assign set_overflow    = wrap_event & ~baud_mode;
   assign set_external    = trigger_event;
   assign toggle_external = wrap_event & up_down_mode;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_two_control <= timer_two_pkg::CONTROL_RESET;
      end else begin
         if (wr_control) begin
            timer_two_control <= pwdata[7:0];
         end
         if (set_overflow) begin
            timer_two_control[timer_two_pkg::OVERFLOW_BIT] <= 1'b1;
         end
         if (toggle_external) begin
            timer_two_control[timer_two_pkg::EXT_FLAG_BIT] <= ~external_event_flag;
         end else if (set_external) begin
            timer_two_control[timer_two_pkg::EXT_FLAG_BIT] <= 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_two_mode_reg <= timer_two_pkg::MODE_RESET;
      end else if (wr_mode) begin
         timer_two_mode_reg <= pwdata[1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         interrupt_enable_reg <= 1'b0;
      end else if (wr_irq_enable) begin
         interrupt_enable_reg <= pwdata[timer_two_pkg::IRQ_ENABLE_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt and baud clock outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_irq     <= 1'b0;
         rx_baud_clock <= 1'b0;
         tx_baud_clock <= 1'b0;
      end else begin
         timer_irq <= interrupt_enable_reg &
                      (overflow_flag | (external_event_flag & ~up_down_mode));
         rx_baud_clock <= receive_baud_select ? wrap_up : aux_timer_overflow;
         tx_baud_clock <= transmit_baud_select ? wrap_up : aux_timer_overflow;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb answer: one wait state, read data and error from flops
   logic [31:0] read_mux;

   always_comb begin
      read_mux = 32'h0000_0000;
      case (paddr)
         timer_two_pkg::CONTROL_OFFSET:     read_mux[7:0] = timer_two_control;
         timer_two_pkg::MODE_OFFSET:        read_mux[1:0] = timer_two_mode_reg;
         timer_two_pkg::COUNT_LOW_OFFSET:   read_mux[7:0] = count[7:0];
         timer_two_pkg::COUNT_HIGH_OFFSET:  read_mux[7:0] = count[15:8];
         timer_two_pkg::RELOAD_LOW_OFFSET:  read_mux[7:0] = reload[7:0];
         timer_two_pkg::RELOAD_HIGH_OFFSET: read_mux[7:0] = reload[15:8];
         timer_two_pkg::IRQ_ENABLE_OFFSET:  read_mux[0]   = interrupt_enable_reg;
         default:                           read_mux      = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~addr_ok;
         if (psel && penable && !pready && !pwrite) begin
            prdata <= read_mux;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence quiet_cycle;
      !wr_en && !trigger_event;
   endsequence

   sequence wrap_seen;
      wrap_up && !baud_mode && !capture_mode && !trigger_reload && !wr_count_low
         && !wr_count_high;
   endsequence

   source_pick_a: assert property (run_control && !count_source_select && !count_pin_fall
                                   && !internal_tick |-> !count_step)
      else $error("count moved without a tick");
   run_hold_a: assert property (!run_control ##0 quiet_cycle |=> $stable(count))
      else $error("count changed while stopped");
   capture_keep_a: assert property (trigger_capture && !wr_count_low && !wr_count_high
                                    && count_step && count != 16'hFFFF
                                    |=> count == $past(count) + 16'h0001 && reload == $past(count))
      else $error("capture disturbed counting");
   reload_up_a: assert property (wrap_seen |=> count == $past(reload) && overflow_flag)
      else $error("overflow did not reload");
   down_wrap_a: assert property (wrap_down && !wr_count_low && !wr_count_high
                                 |=> count == 16'hFFFF)
      else $error("underflow did not load all ones");
   baud_noflag_a: assert property (baud_mode && !overflow_flag && !wr_control
                                   |=> !overflow_flag)
      else $error("overflow flag set in baud mode");
   ext_toggle_a: assert property (toggle_external && !wr_control
                                  |=> external_event_flag != $past(external_event_flag))
      else $error("external flag did not toggle");
   irq_gate_a: assert property (!interrupt_enable_reg ##1 !interrupt_enable_reg
                                |-> !timer_irq)
      else $error("interrupt raised while disabled");
   rx_route_a: assert property (!receive_baud_select && aux_timer_overflow
                                |=> rx_baud_clock)
      else $error("receive clock not from aux timer");
   tx_route_a: assert property (transmit_baud_select && !wrap_up |=> !tx_baud_clock)
      else $error("transmit clock pulse without overflow");
   trig_ignore_a: assert property (!external_trigger_enable && !wr_control
                                   && !external_event_flag && !toggle_external
                                   |=> !external_event_flag)
      else $error("trigger acted while disabled");

endmodule

// ==== rtl/timer_two_pkg.sv ====
// constants for the capture / reload timer and its register map
package timer_two_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register byte offsets
   localparam logic [7:0] CONTROL_OFFSET     = 8'h00;
   localparam logic [7:0] MODE_OFFSET        = 8'h04;
   localparam logic [7:0] COUNT_LOW_OFFSET   = 8'h08;
   localparam logic [7:0] COUNT_HIGH_OFFSET  = 8'h0C;
   localparam logic [7:0] RELOAD_LOW_OFFSET  = 8'h10;
   localparam logic [7:0] RELOAD_HIGH_OFFSET = 8'h14;
   localparam logic [7:0] IRQ_ENABLE_OFFSET  = 8'h18;

   ////////////////////////////////////////////////////////////////////////////
   // control register fields
   localparam int OVERFLOW_BIT       = 7;
   localparam int EXT_FLAG_BIT       = 6;
   localparam int RX_BAUD_BIT        = 5;
   localparam int TX_BAUD_BIT        = 4;
   localparam int TRIGGER_ENABLE_BIT = 3;
   localparam int RUN_BIT            = 2;
   localparam int SOURCE_BIT         = 1;
   localparam int CAPTURE_BIT        = 0;

   // mode register and interrupt enable fields
   localparam int DOWN_ENABLE_BIT = 0;
   localparam int SIX_CLOCK_BIT   = 1;
   localparam int IRQ_ENABLE_BIT  = 0;

   ////////////////////////////////////////////////////////////////////////////
   // reset values and count limits
   localparam logic [7:0]  CONTROL_RESET = 8'h00;
   localparam logic [1:0]  MODE_RESET    = 2'h0;
   localparam logic [15:0] COUNT_RESET   = 16'h0000;
   localparam logic [15:0] RELOAD_RESET  = 16'h0000;
   localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;

   ////////////////////////////////////////////////////////////////////////////
   // core clock cycles per count tick
   localparam logic [3:0] TICK_DIV_12CLK = 4'hC;
   localparam logic [3:0] TICK_DIV_6CLK  = 4'h6;
   localparam logic [3:0] BAUD_DIV_12CLK = 4'h2;
   localparam logic [3:0] BAUD_DIV_6CLK  = 4'h1;

endpackage
